// ===== verilog/fpdc_consts.svh
/*
 Constants for the floating point datapath control block: instruction field
 positions, status bit positions, mode bit positions and pipeline depth.
 Assumes it is included by bare name from verilog/.
*/
`ifndef FPDC_CONSTS_SVH
`define FPDC_CONSTS_SVH

`define FPDC_F_HI        32
`define FPDC_F_LO        30
`define FPDC_A_HI        29
`define FPDC_A_LO        25
`define FPDC_B_HI        24
`define FPDC_B_LO        20
`define FPDC_C_HI        19
`define FPDC_C_LO        15
`define FPDC_WEN_BIT     14
`define FPDC_IO_HI       13
`define FPDC_IO_LO       12
`define FPDC_D_HI        11
`define FPDC_D_LO        7
`define FPDC_ABS_HI      6
`define FPDC_ABS_LO      4
`define FPDC_ADST_HI     3
`define FPDC_ADST_LO     2
`define FPDC_MBIN_BIT    1
`define FPDC_COND_UPDATE_ENABLE_BIT    0
`define FPDC_MBS_BIT     33

`define FPDC_MODE_UFL_EN 2
`define FPDC_MODE_LBYP   3
`define FPDC_MODE_SBYP   4
`define FPDC_MODE_OFL_EN 5
`define FPDC_MODE_COPRO  6
`define FPDC_MODE_DLOAD  9
`define FPDC_MODE_MFB    11
`define FPDC_MODE_SPLIT  12
`define FPDC_MODE_RESET  13'h0000

`define FPDC_STAT_OFL    0
`define FPDC_STAT_UFL    1
`define FPDC_STAT_RESET  2'h0

`define FPDC_PIPE_DEPTH  3

`endif

// ===== verilog/fpdc_pkg.sv
/*
 Types for the floating point datapath control block.
 Assumes fpdc_consts.svh is on the include path.
*/
package fpdc_pkg;

  typedef enum logic [2:0] {
    FPDC_FN_MISC  = 3'h0,
    FPDC_FN_SUBR  = 3'h1,
    FPDC_FN_SUB   = 3'h2,
    FPDC_FN_ADD   = 3'h3,
    FPDC_FN_RSVD  = 3'h4,
    FPDC_FN_MNA   = 3'h5,
    FPDC_FN_MNS   = 3'h6,
    FPDC_FN_MAC   = 3'h7
  } fpdc_func_t;

  typedef enum logic [3:0] {
    FPDC_OP_NONE  = 4'h0,
    FPDC_OP_MAC   = 4'h1,
    FPDC_OP_MNS   = 4'h2,
    FPDC_OP_MNA   = 4'h3,
    FPDC_OP_ADD   = 4'h4,
    FPDC_OP_SUB   = 4'h5,
    FPDC_OP_SUBR  = 4'h6,
    FPDC_OP_LUT   = 4'h7,
    FPDC_OP_FIX   = 4'h8,
    FPDC_OP_FLOAT = 4'h9,
    FPDC_OP_ABS   = 4'hA,
    FPDC_OP_LDM   = 4'hB,
    FPDC_OP_RDST  = 4'hC,
    FPDC_OP_CLST  = 4'hD,
    FPDC_OP_RSVD  = 4'hE
  } fpdc_op_t;

  typedef enum logic [1:0] {
    FPDC_IO_NOP   = 2'h0,
    FPDC_IO_LDC   = 2'h1,
    FPDC_IO_ST    = 2'h2,
    FPDC_IO_LD    = 2'h3
  } fpdc_io_t;

  typedef enum logic [1:0] {
    FPDC_CSRC_RES = 2'h0,
    FPDC_CSRC_X   = 2'h1,
    FPDC_CSRC_LUT = 2'h2,
    FPDC_CSRC_X2  = 2'h3
  } fpdc_csrc_t;

endpackage : fpdc_pkg

// ===== verilog/fpdc_decode.sv
/*
 Instruction decoder: maps the function field and, for miscellaneous
 operations, the B address field to one operation code.
 Assumes a registered instruction word at its input; purely combinational.
*/
`timescale 1ns/1ps
`include "fpdc_consts.svh"

module fpdc_decode (
  input  wire logic [2:0]       func,
  input  wire logic [4:0]       b_addr,
  output fpdc_pkg::fpdc_op_t    op
);
  import fpdc_pkg::*;

  always_comb begin
    op = FPDC_OP_RSVD;
    case (fpdc_func_t'(func))
      FPDC_FN_MAC:  op = FPDC_OP_MAC;
      FPDC_FN_MNS:  op = FPDC_OP_MNS;
      FPDC_FN_MNA:  op = FPDC_OP_MNA;
      FPDC_FN_ADD:  op = FPDC_OP_ADD;
      FPDC_FN_SUB:  op = FPDC_OP_SUB;
      FPDC_FN_SUBR: op = FPDC_OP_SUBR;
      FPDC_FN_MISC: begin
        case (b_addr)
          5'h07:   op = FPDC_OP_LUT;
          5'h06:   op = FPDC_OP_FIX;
          5'h05:   op = FPDC_OP_FLOAT;
          5'h04:   op = FPDC_OP_ABS;
          5'h03:   op = FPDC_OP_LDM;
          5'h01:   op = FPDC_OP_RDST;
          5'h00:   op = FPDC_OP_CLST;
          default: op = FPDC_OP_RSVD;
        endcase
      end
      default:      op = FPDC_OP_RSVD;
    endcase
  end

endmodule : fpdc_decode

// ===== verilog/fpdc_ctrl.sv
/*
 Control logic of a 32-bit floating point datapath: instruction register,
 three-stage pipeline of write controls, bypass selects, mode and status
 registers, exception output and I/O port direction.
 Assumes the sequencer drives the code word and ports synchronous to clk;
 the arithmetic units sit outside and report flags back.
*/
`timescale 1ns/1ps
`include "fpdc_consts.svh"

module fpdc_ctrl #(
  parameter int DATA_W  = 32,
  parameter int CODE_W  = 34
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [CODE_W-1:0]    code_in,
  input  wire logic                 cancel_write_n,
  input  wire logic                 abort_n,
  input  wire logic                 stall_n,
  input  wire logic                 io_port_out_enable_n,
  input  wire logic [DATA_W-1:0]    x_in,
  output logic      [DATA_W-1:0]    x_out,
  output logic                      x_oe,
  input  wire logic [DATA_W-1:0]    y_in,
  input  wire logic [DATA_W-1:0]    d_read_data,
  input  wire logic [DATA_W-1:0]    result_bus,
  input  wire logic [DATA_W-1:0]    lut_data,
  input  wire logic                 res_overflow,
  input  wire logic                 res_underflow,
  input  wire logic                 res_le_zero,
  input  wire logic                 res_zero,
  output logic      [DATA_W-1:0]    c_bus,
  output logic      [DATA_W-1:0]    x_reg,
  output logic      [DATA_W-1:0]    x_fall_reg,
  output logic      [DATA_W-1:0]    y_reg,
  output logic                      a_from_x,
  output logic                      mb_from_c,
  output logic                      b_from_y,
  output logic                      d_write,
  output logic      [4:0]           d_addr,
  output logic                      c_write,
  output logic      [4:0]           c_addr,
  output logic      [1:0]           treg_dest,
  output logic                      treg_write,
  output fpdc_pkg::fpdc_op_t        op_issue,
  output logic      [12:0]          mode,
  output logic      [1:0]           fp_exception_status,
  output logic                      exception_out,
  output logic                      le_zero_condition,
  output logic                      zero_condition
);
  import fpdc_pkg::*;

  localparam int DEPTH = `FPDC_PIPE_DEPTH;

  // ****************************************
  // Instruction register and decode
  // ****************************************
  logic [CODE_W-1:0] ir;
  fpdc_op_t          op;
  fpdc_io_t          io;
  logic [4:0]        a_addr;
  logic [4:0]        b_addr;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ir <= {CODE_W{1'b1}};
    end else begin
      ir <= code_in;
    end
  end

  fpdc_decode u_decode (
    .func   (ir[`FPDC_F_HI:`FPDC_F_LO]),
    .b_addr (ir[`FPDC_B_HI:`FPDC_B_LO]),
    .op     (op)
  );

  assign io       = fpdc_io_t'(ir[`FPDC_IO_HI:`FPDC_IO_LO]);
  assign a_addr   = ir[`FPDC_A_HI:`FPDC_A_LO];
  assign b_addr   = ir[`FPDC_B_HI:`FPDC_B_LO];
  assign d_addr   = ir[`FPDC_D_HI:`FPDC_D_LO];
  assign op_issue = op;
  assign b_from_y = ir[`FPDC_MBS_BIT];

  function automatic logic is_load(input fpdc_io_t v);
    is_load = (v == FPDC_IO_LD) || (v == FPDC_IO_LDC);
  endfunction : is_load

  function automatic logic writes_result(input fpdc_op_t v);
    writes_result = !(v == FPDC_OP_LDM || v == FPDC_OP_RDST ||
                      v == FPDC_OP_CLST || v == FPDC_OP_RSVD ||
                      v == FPDC_OP_NONE);
  endfunction : writes_result

  // ****************************************
  // Write-control pipeline
  // ****************************************
  // Stage 0 is the cycle after issue; stage DEPTH-1 is the write-back cycle.
  logic [4:0]     c_addr_p [DEPTH];
  logic           wen_n_p  [DEPTH];
  logic           cond_update_enable_p   [DEPTH];
  logic [1:0]     adst_p   [DEPTH];
  fpdc_op_t       op_p     [DEPTH];
  logic           live_p   [DEPTH];
  logic           abort_q;
  logic           live0;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= !abort_n;
    end
  end

  assign live0 = cancel_write_n && abort_n && !abort_q && stall_n;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        c_addr_p[i] <= 5'h00;
        wen_n_p[i]  <= 1'b1;
        cond_update_enable_p[i]   <= 1'b0;
        adst_p[i]   <= 2'h3;
        op_p[i]     <= FPDC_OP_NONE;
        live_p[i]   <= 1'b0;
      end
    end else begin
      c_addr_p[0] <= ir[`FPDC_C_HI:`FPDC_C_LO];
      wen_n_p[0]  <= ir[`FPDC_WEN_BIT] || !live0;
      cond_update_enable_p[0]   <= ir[`FPDC_COND_UPDATE_ENABLE_BIT] && live0;
      adst_p[0]   <= live0 ? ir[`FPDC_ADST_HI:`FPDC_ADST_LO] : 2'h3;
      op_p[0]     <= op;
      live_p[0]   <= live0;
      for (int i = 1; i < DEPTH; i++) begin
        c_addr_p[i] <= c_addr_p[i-1];
        wen_n_p[i]  <= wen_n_p[i-1];
        cond_update_enable_p[i]   <= cond_update_enable_p[i-1];
        adst_p[i]   <= adst_p[i-1];
        op_p[i]     <= op_p[i-1];
        live_p[i]   <= live_p[i-1];
      end
    end
  end

  assign c_addr     = c_addr_p[DEPTH-1];
  assign c_write    = !wen_n_p[DEPTH-1];
  assign treg_dest  = adst_p[DEPTH-1];
  assign treg_write = live_p[DEPTH-1] && (adst_p[DEPTH-1] != 2'h3) &&
                      writes_result(op_p[DEPTH-1]);

  // ****************************************
  // Mode register
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode <= `FPDC_MODE_RESET;
    end else if (op == FPDC_OP_LDM) begin
      mode <= {ir[`FPDC_ABS_HI:`FPDC_ABS_LO], ir[`FPDC_C_HI:`FPDC_C_LO], a_addr};
    end
  end

  // ****************************************
  // Port registers and bypass selects
  // ****************************************
  logic copro;
  logic ld_now;
  logic st_now;
  logic st_q;
  logic rdst_q;
  logic [DATA_W-1:0] c_q;

  assign copro  = mode[`FPDC_MODE_COPRO];
  assign ld_now = copro ? 1'b0 : is_load(io);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      x_reg <= '0;
    end else begin
      x_reg <= x_in;
    end
  end

  always_ff @(negedge clk) begin
    if (!rst_b) begin
      x_fall_reg <= '0;
    end else if (mode[`FPDC_MODE_DLOAD]) begin
      x_fall_reg <= x_in;
    end
  end

  always_ff @(negedge clk) begin
    if (!rst_b) begin
      y_reg <= '0;
    end else if (mode[`FPDC_MODE_SPLIT]) begin
      y_reg <= y_in;
    end
  end

  logic [DATA_W-1:0] y_rise;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      y_rise <= '0;
    end else begin
      y_rise <= y_in;
    end
  end

  logic copro_ld_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      copro_ld_q <= 1'b0;
    end else begin
      copro_ld_q <= copro && is_load(io);
    end
  end

  assign d_write  = ld_now || copro_ld_q;

  assign a_from_x = !copro && mode[`FPDC_MODE_LBYP] && (a_addr == d_addr) &&
                    (is_load(io) || io == FPDC_IO_NOP);

  assign mb_from_c = ir[`FPDC_MBIN_BIT] ||
                     (!copro && mode[`FPDC_MODE_MFB] &&
                      (b_addr == c_addr_p[DEPTH-1]) && !wen_n_p[DEPTH-1]);

  always_comb begin
    c_bus = result_bus;
    if (op_p[DEPTH-1] == FPDC_OP_LUT) begin
      c_bus = lut_data;
    end else if (io == FPDC_IO_LDC && !copro) begin
      c_bus = x_reg;
    end else if (mode[`FPDC_MODE_DLOAD]) begin
      c_bus = x_fall_reg;
    end else if (mode[`FPDC_MODE_SPLIT]) begin
      c_bus = y_reg;
    end
  end

  assign st_now = (io == FPDC_IO_ST);

  // drive the cycle after a store
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q   <= 1'b0;
      rdst_q <= 1'b0;
      c_q    <= '0;
    end else begin
      st_q   <= st_now && stall_n;
      rdst_q <= (op == FPDC_OP_RDST);
      if (!copro && mode[`FPDC_MODE_SBYP] && (d_addr == c_addr_p[DEPTH-1]) &&
          !wen_n_p[DEPTH-1]) begin
        c_q <= c_bus;
      end else begin
        c_q <= d_read_data;
      end
    end
  end

  // read status relies on store code
  always_comb begin
    x_out = c_q;
    if (rdst_q) begin
      x_out = {{(DATA_W-2){1'b0}}, fp_exception_status};
    end
  end

  assign x_oe = st_q && !io_port_out_enable_n;

  // ****************************************
  // Status, exception and condition
  // ****************************************
  logic last_live;
  assign last_live = live_p[DEPTH-1] && writes_result(op_p[DEPTH-1]) &&
                     (op_p[DEPTH-1] != FPDC_OP_LUT);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fp_exception_status <= `FPDC_STAT_RESET;
    end else begin
      fp_exception_status <= ((op == FPDC_OP_CLST) && live0) ? `FPDC_STAT_RESET
                                                               : fp_exception_status;
      if (last_live && res_overflow) begin
        fp_exception_status[`FPDC_STAT_OFL] <= 1'b1;
      end
      if (last_live && res_underflow) begin
        fp_exception_status[`FPDC_STAT_UFL] <= 1'b1;
      end
    end
  end

  assign exception_out =
    (mode[`FPDC_MODE_OFL_EN] && fp_exception_status[`FPDC_STAT_OFL]) ||
    (mode[`FPDC_MODE_UFL_EN] && fp_exception_status[`FPDC_STAT_UFL]);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      le_zero_condition <= 1'b0;
      zero_condition    <= 1'b0;
    end else if (cond_update_enable_p[DEPTH-1]) begin
      le_zero_condition <= res_le_zero;
      zero_condition    <= res_zero;
    end
  end

  // Rising-edge Y copy is kept for single transfer mode; it drives no output in any mode.
  logic unused_y;
  assign unused_y = ^y_rise;

endmodule : fpdc_ctrl

// ===== testbench/fpdc_ctrl_props.sv
/*
 Checker bound to fpdc_ctrl: write-back timing, bypass selects, port
 direction and status behaviour at the ports.
 Assumes abort_n and stall_n stay high.
*/
`timescale 1ns/1ps
module fpdc_ctrl_props #(
  parameter int DATA_W = 32,
  parameter int CODE_W = 34
) (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic [CODE_W-1:0]  code_in,
  input wire logic               io_port_out_enable_n,
  input wire logic [DATA_W-1:0]  d_read_data,
  input wire logic               res_overflow,
  input wire logic [DATA_W-1:0]  x_out,
  input wire logic               x_oe,
  input wire logic               a_from_x,
  input wire logic               mb_from_c,
  input wire logic               c_write,
  input wire logic [4:0]         c_addr,
  input wire fpdc_pkg::fpdc_op_t op_issue,
  input wire logic [12:0]        mode,
  input wire logic [1:0]         fp_exception_status,
  input wire logic               exception_out
);
  import fpdc_pkg::*;
  // ****************
  // History
  // ****************
  logic [4:0] live;
  logic [5:0] clr_seen;
  // Keeps $past from reaching back into reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      live <= 5'h00;
      clr_seen <= 6'h00;
    end else begin
      live <= {live[3:0], 1'b1};
      clr_seen <= {clr_seen[4:0], op_issue == FPDC_OP_CLST};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ****************
  // Properties
  // ****************
  AST_RESET_CLEARS: assert property (disable iff (1'b0)
    !rst_b |=> mode == 13'h0000 && fp_exception_status == 2'h0) else $error("reset not clean");
  AST_EXC_GATE: assert property (exception_out == ((mode[5] & fp_exception_status[0])
    | (mode[2] & fp_exception_status[1]))) else $error("exception output wrong");
  AST_CWRITE_SRC: assert property (c_write |-> !$past(code_in[14], 4)
    && c_addr == $past(code_in[19:15], 4)) else $error("C write without cause");
  AST_OE_STORE: assert property (live[1] |-> x_oe == (!io_port_out_enable_n
    && $past(code_in[13:12], 2) == 2'h2)) else $error("port enable wrong");
  AST_LOAD_BYPASS: assert property (live[0] |-> a_from_x == (mode[3] && !mode[6]
    && $past(code_in[13:12]) != 2'h2 && $past(code_in[29:25]) == $past(code_in[11:7])))
    else $error("load bypass select wrong");
  AST_STORE_DPORT: assert property (x_oe && !$past(mode[4])
    && $past(op_issue) != FPDC_OP_RDST |-> x_out == $past(d_read_data))
    else $error("store not from D port");
  AST_READ_STATUS: assert property ($past(op_issue) == FPDC_OP_RDST && x_oe
    |-> x_out == {{(DATA_W-2){1'b0}}, fp_exception_status}) else $error("status read wrong");
  AST_MB_FEED: assert property (mb_from_c && live[0] |-> $past(code_in[1])
    || (mode[11] && !$past(code_in[14], 4) && $past(code_in[24:20]) == $past(code_in[19:15], 4)))
    else $error("multiplier feedback without cause");
  AST_STAT_HOLD: assert property (|($past(fp_exception_status) & ~fp_exception_status)
    |-> |clr_seen) else $error("status dropped without clear");
  AST_STAT_SET: assert property (c_write && res_overflow |=> fp_exception_status[0])
    else $error("overflow not recorded");
  COV_WRITE: cover property (c_write);
  COV_BYPASS: cover property (a_from_x);
  COV_FEED: cover property (mb_from_c && c_write);
endmodule : fpdc_ctrl_props

bind fpdc_ctrl fpdc_ctrl_props #(.DATA_W(DATA_W), .CODE_W(CODE_W)) props_u (
  .clk(clk), .rst_b(rst_b), .code_in(code_in), .io_port_out_enable_n(io_port_out_enable_n),
  .d_read_data(d_read_data), .res_overflow(res_overflow), .x_out(x_out), .x_oe(x_oe),
  .a_from_x(a_from_x), .mb_from_c(mb_from_c), .c_write(c_write), .c_addr(c_addr),
  .op_issue(op_issue), .mode(mode), .fp_exception_status(fp_exception_status),
  .exception_out(exception_out)
);

// ===== testbench/fpdc_seq_model.sv
/*
 Sequencer model: packs instruction words, presents code and port data.
 Assumes one caller, one issue per clock cycle.
*/
`timescale 1ns/1ps
module fpdc_seq_model (
  input  wire logic        clk,
  output logic      [33:0] code_in,
  output logic      [31:0] x_in,
  output logic      [31:0] y_in
);
  import fpdc_pkg::*;
  initial begin
    code_in = 34'h0;
    {x_in, y_in} = 64'h0;
  end
  // bench never aims a load at a pending C address
  task automatic issue(input logic [2:0] f, input logic [4:0] a, input logic [4:0] b,
      input logic [4:0] c, input logic wen, input logic [1:0] io, input logic [4:0] d,
      input logic [2:0] abs, input logic cond_update_enable, input logic [31:0] xd);
    logic [4:0] cf;
    logic [1:0] iof;
    cf = c;
    iof = io;
    if (f == 3'h0 && b == 5'h03) cf[1] = 1'b0;
    if (f == 3'h0 && b == 5'h01) iof = FPDC_IO_ST;
    @(posedge clk);
    #1;
    code_in = {1'b0, f, a, b, cf, wen, iof, d, abs, 2'h3, 1'b0, cond_update_enable};
    x_in = xd;
  endtask : issue
  task automatic put_data(input logic [31:0] xd, input logic [31:0] yd);
    @(posedge clk);
    #1;
    {x_in, y_in} = {xd, yd};
  endtask : put_data
endmodule : fpdc_seq_model

// ===== testbench/fpdc_ctrl_tb.sv
/*
 Testbench for fpdc_ctrl: sequences of issued instructions with expected values.
 Assumes the sequencer model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module fpdc_ctrl_tb;
  import fpdc_pkg::*;
  localparam logic [31:0] RB = 32'h3F80_0000;
  localparam logic [31:0] DR = 32'h1234_5678;
  localparam logic [31:0] LV = 32'h4000_0001;
  localparam logic [31:0] XD = 32'hA5A5_0001;
  logic        clk, rst_b, cancel_write_n, io_port_out_enable_n;
  logic        res_overflow, res_underflow, res_le_zero, res_zero;
  logic [33:0] code_in;
  logic [31:0] x_in, y_in, x_out, d_read_data, result_bus, lut_data, c_bus, x_fall_reg, y_reg;
  logic        x_oe, a_from_x, mb_from_c, d_write, c_write, exception_out;
  logic        le_zero_condition, zero_condition;
  logic [4:0]  c_addr, fb, d_addr;
  logic [31:0] x_reg;
  logic [2:0]  fn;
  logic [12:0] mode;
  logic [1:0]  fp_exception_status;
  fpdc_op_t    op_issue;
  int          mismatches, n_compared;
  fpdc_op_t    exp_op [16] = '{FPDC_OP_SUBR, FPDC_OP_SUB, FPDC_OP_ADD, FPDC_OP_RSVD,
    FPDC_OP_MNA, FPDC_OP_MNS, FPDC_OP_MAC, FPDC_OP_CLST, FPDC_OP_RDST, FPDC_OP_RSVD,
    FPDC_OP_LDM, FPDC_OP_ABS, FPDC_OP_FLOAT, FPDC_OP_FIX, FPDC_OP_LUT, FPDC_OP_RSVD};

  fpdc_seq_model seq_u (.clk(clk), .code_in(code_in), .x_in(x_in), .y_in(y_in));
  fpdc_ctrl dut_u (.clk(clk), .rst_b(rst_b), .code_in(code_in), .cancel_write_n(cancel_write_n),
    .abort_n(1'b1), .stall_n(1'b1), .io_port_out_enable_n(io_port_out_enable_n), .x_in(x_in),
    .x_out(x_out), .x_oe(x_oe), .y_in(y_in), .d_read_data(d_read_data), .result_bus(result_bus),
    .lut_data(lut_data), .res_overflow(res_overflow), .res_underflow(res_underflow),
    .res_le_zero(res_le_zero), .res_zero(res_zero), .c_bus(c_bus), .x_reg(x_reg),
    .x_fall_reg(x_fall_reg), .y_reg(y_reg), .a_from_x(a_from_x), .mb_from_c(mb_from_c),
    .b_from_y(), .d_write(d_write), .d_addr(d_addr), .c_write(c_write), .c_addr(c_addr),
    .treg_dest(), .treg_write(), .op_issue(op_issue), .mode(mode),
    .fp_exception_status(fp_exception_status), .exception_out(exception_out),
    .le_zero_condition(le_zero_condition), .zero_condition(zero_condition));

  always #50 clk = ~clk;
  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic nop(input int n);
    repeat (n) seq_u.issue(3'h3, 5'h01, 5'h02, 5'h00, 1'b1, 2'h0, 5'h02, 3'h7, 1'b0, 32'h0);
  endtask : nop
  task automatic load_mode(input logic [12:0] m);
    seq_u.issue(3'h0, m[4:0], 5'h03, m[9:5], 1'b1, 2'h0, 5'h1F, m[12:10], 1'b0, 32'h0);
    nop(4);
    check(32'(mode), 32'(m));
  endtask : load_mode
  // Flags are shown only in the write-back cycle, three after issue
  task automatic wb_run(input logic cond_update_enable, input logic canc, input logic [3:0] fl);
    seq_u.issue(3'h3, 5'h01, 5'h02, 5'h07, 1'b0, 2'h0, 5'h09, 3'h7, cond_update_enable, 32'h0);
    nop(1);
    cancel_write_n = !canc;
    nop(1);
    cancel_write_n = 1'b1;
    nop(2);
    {res_overflow, res_underflow, res_le_zero, res_zero} = fl;
    check(32'(c_write), 32'(!canc));
    nop(1);
    {res_overflow, res_underflow, res_le_zero, res_zero} = 4'h0;
    nop(1);
  endtask : wb_run
  // ****************
  // Sequence
  // ****************
  initial begin
    {clk, rst_b, cancel_write_n, io_port_out_enable_n} = 4'h2;
    {d_read_data, result_bus, lut_data} = {DR, RB, LV};
    {res_overflow, res_underflow, res_le_zero, res_zero} = 4'h0;
    {mismatches, n_compared} = 64'h0;
    repeat (5) @(posedge clk);
    #1;
    rst_b = 1'b1;
    check(32'({mode, fp_exception_status, exception_out}), 32'h0);
    for (int i = 0; i < 16; i++) begin
      fn = (i < 7) ? 3'(i + 1) : 3'h0;
      fb = (i < 7) ? 5'h00 : 5'(i - 7);
      seq_u.issue(fn, 5'h00, fb, 5'h00, 1'b1, 2'h0, 5'h02, 3'h0, 1'b0, 32'h0);
      nop(1);
      check(32'(op_issue), 32'(exp_op[i]));
    end
    load_mode(13'h083C);
    for (int i = 0; i < 4; i++) begin
      seq_u.issue(3'h3, 5'h04, 5'h02, 5'h00, 1'b1, 2'(i), 5'h04, 3'h7, 1'b0, XD);
      nop(1);
      check(32'(d_write), 32'(i % 2));
      check(32'(a_from_x), 32'(i != 2));
      check(c_bus, (i == 1) ? XD : RB);
      check(32'(d_addr), 32'h4);
      check(x_reg, XD);
    end
    seq_u.issue(3'h0, 5'h04, 5'h07, 5'h00, 1'b1, 2'h0, 5'h02, 3'h0, 1'b0, 32'h0);
    nop(2);
    seq_u.issue(3'h3, 5'h03, 5'h02, 5'h00, 1'b1, 2'h1, 5'h04, 3'h7, 1'b0, XD);
    nop(1);
    check(c_bus, LV);
    check(32'(a_from_x), 32'h0);
    for (int j = 0; j < 3; j++) begin
      if (j == 2) load_mode(13'h082C);
      seq_u.issue(3'h7, 5'h01, 5'h02, 5'h05, 1'(j == 1), 2'h0, 5'h09, 3'h0, 1'b0, 32'h0);
      nop(2);
      seq_u.issue(3'h3, 5'h01, 5'h05, 5'h00, 1'b1, 2'h2, 5'h05, 3'h7, 1'b0, 32'h0);
      nop(1);
      check(32'({c_write, c_addr}), (j == 1) ? 32'h05 : 32'h25);
      check(32'(mb_from_c), 32'(j != 1));
      nop(1);
      check(32'(x_oe), 32'h1);
      check(x_out, (j == 0) ? RB : DR);
    end
    io_port_out_enable_n = 1'b1;
    seq_u.issue(3'h3, 5'h01, 5'h02, 5'h00, 1'b1, 2'h2, 5'h05, 3'h7, 1'b0, 32'h0);
    nop(2);
    check(32'(x_oe), 32'h0);
    io_port_out_enable_n = 1'b0;
    wb_run(1'b1, 1'b0, 4'hB);
    check(32'({fp_exception_status, exception_out}), 32'h3);
    check(32'({le_zero_condition, zero_condition}), 32'h3);
    wb_run(1'b1, 1'b1, 4'h4);
    check(32'({fp_exception_status, le_zero_condition, zero_condition}), 32'h7);
    wb_run(1'b0, 1'b0, 4'h4);
    check(32'({fp_exception_status, le_zero_condition, zero_condition}), 32'hF);
    seq_u.issue(3'h0, 5'h01, 5'h01, 5'h00, 1'b1, 2'h2, 5'h02, 3'h0, 1'b0, 32'h0);
    nop(2);
    check(x_out, 32'h3);
    seq_u.issue(3'h0, 5'h01, 5'h00, 5'h00, 1'b1, 2'h0, 5'h02, 3'h0, 1'b0, 32'h0);
    nop(4);
    check(32'({fp_exception_status, exception_out}), 32'h0);
    load_mode(13'h1A2C);
    seq_u.put_data(XD, DR);
    @(negedge clk);
    #1;
    check(y_reg, DR);
    check(x_fall_reg, XD);
    print_verdict();
  end
endmodule : fpdc_ctrl_tb
